/* vxd_pkg.sv */
// Behaviour
// RULE_01: fetch packets are 256 bits, eight slots
// RULE_02: lsb one chains next instruction in packet
// RULE_03: lsb zero ends current execute packet
// RULE_04: at most eight instructions per packet
// RULE_05: execute packets may span two fetch packets
// RULE_06: one to eight packets per fetch packet
// RULE_07: one execute packet issued per clock
// RULE_08: next fetch waits until packet fully drained
// RULE_09: unit-select field picks target functional unit
package vxd_pkg;
  localparam int FP_W = 256;
  localparam int SLOTS = 8;
  localparam int INS_W = 32;
  localparam int UNITS = 8;
  localparam int ADDR_W = 32;
  localparam int CHAIN_BIT = 0;
  // unit-select field position inside each instruction
  localparam int USEL_LO = 1;
  localparam int USEL_W = 3;
  localparam logic [ADDR_W-1:0] FP_BYTES = 32'h0000_0020;
  localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;
  localparam logic [3:0] SLOT_NONE = 4'h8;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_WAIT = 3'b010,
    ST_ISSUE = 3'b100
  } vxd_state_t;

  // target unit of one instruction
  function automatic logic [USEL_W-1:0] unit_of(input logic [INS_W-1:0] ins);
    return ins[USEL_LO +: USEL_W];
  endfunction
endpackage

/* vxd_slot_if.sv */
`timescale 1ns/1ps
`default_nettype none
// fetch packet handed from the core to the slot buffer
interface vxd_slot_if;
  import vxd_pkg::*;
  logic load;
  logic [FP_W-1:0] data;
  logic [SLOTS-1:0][INS_W-1:0] slot;
  modport core (output load, output data, input slot);
  modport buf_side (input load, input data, output slot);
endinterface
`default_nettype wire

/* vxd_slot_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// holds the current fetch packet as eight registered slots
module vxd_slot_buf
  import vxd_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // packet port
  vxd_slot_if.buf_side sif
);
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      logic [INS_W-1:0] slot_q;
      // one slot per instruction lane
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          slot_q <= '0;
        end else if (sif.load) begin
          slot_q <= sif.data[g*INS_W +: INS_W]; // RULE_01
        end
      end
      assign sif.slot[g] = slot_q;
    end
  endgenerate
endmodule
`default_nettype wire

/* vxd_dispatch.sv */
`timescale 1ns/1ps
`default_nettype none
module vxd_dispatch
  import vxd_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // program memory fetch path
  output logic FETCH_REQ,
  output logic [ADDR_W-1:0] FETCH_ADDR,
  input wire logic FETCH_VALID,
  input wire logic [FP_W-1:0] FETCH_DATA,
  // functional unit issue
  output logic ISSUE_VALID,
  output logic [UNITS-1:0] UNIT_VALID,
  output logic [UNITS-1:0][INS_W-1:0] UNIT_INS
);
  // ****************************************
  // state
  // ****************************************
  vxd_state_t state_q;
  vxd_state_t state_d;
  logic [3:0] pos_q;
  logic [3:0] pos_d;
  logic [ADDR_W-1:0] pc_q;
  logic [ADDR_W-1:0] pc_d;
  // partial packet carried across a fetch boundary
  logic [UNITS-1:0] carry_v_q;
  logic [UNITS-1:0] carry_v_d;
  logic [UNITS-1:0][INS_W-1:0] carry_i_q;
  logic [UNITS-1:0][INS_W-1:0] carry_i_d;
  logic [3:0] carry_n_q;
  logic [3:0] carry_n_d;
  // state strobes, decoded once; fire feeds two processes, take_fp the eight buffer slot registers
  logic in_fetch;
  logic in_issue;
  logic take_fp;
  logic fire;

  // the buffer loads only on the edge that takes a fetch packet
  vxd_slot_if sif();
  assign sif.load = take_fp;
  assign sif.data = FETCH_DATA;

  vxd_slot_buf u_buf (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .sif(sif)
  );

  // ****************************************
  // packet scan
  // ****************************************
  logic [UNITS-1:0] pk_v;
  logic [UNITS-1:0][INS_W-1:0] pk_i;
  logic [3:0] end_pos;
  logic closed;
  logic [3:0] cnt;
  // walk chain bits from pos_q; stop at a zero or at packet end
  always_comb begin
    logic run;
    run = 1'b1;
    pk_v = carry_v_q;
    pk_i = carry_i_q;
    end_pos = SLOT_NONE;
    closed = 1'b0;
    cnt = carry_n_q;
    for (int s = 0; s < SLOTS; s++) begin
      // a set chain bit keeps the walk going into the next slot
      if (run && 4'(s) >= pos_q) begin // RULE_02
        pk_v[unit_of(sif.slot[s])] = 1'b1; // RULE_09
        pk_i[unit_of(sif.slot[s])] = sif.slot[s]; // RULE_07
        cnt = cnt + 4'h1;
        if (!sif.slot[s][CHAIN_BIT] || cnt == 4'(SLOTS)) begin
          run = 1'b0; // RULE_03 RULE_04
          closed = 1'b1;
          end_pos = 4'(s) + 4'h1;
        end
      end
    end
  end

  // ****************************************
  // state strobes
  // ****************************************
  // decoded once; fire feeds two processes, take_fp the eight buffer slot registers
  assign in_fetch = (state_q == ST_FETCH);
  assign in_issue = (state_q == ST_ISSUE);
  // data offered outside the wait state is simply ignored
  assign take_fp = (state_q == ST_WAIT) && FETCH_VALID;
  assign fire = in_issue && closed; // RULE_07

  // ****************************************
  // control
  // ****************************************
  // one process decides every move; fetch is held until the buffer drains
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    pc_d = pc_q;
    carry_v_d = carry_v_q;
    carry_i_d = carry_i_q;
    carry_n_d = carry_n_q;
    unique case (state_q)
      ST_FETCH: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        // any memory latency of one cycle or more is tolerated
        if (FETCH_VALID) begin
          state_d = ST_ISSUE;
          pos_d = '0;
          pc_d = pc_q + FP_BYTES; // RULE_01
        end
      end
      ST_ISSUE: begin
        if (closed) begin
          carry_v_d = '0; // RULE_05
          carry_n_d = '0;
          pos_d = end_pos; // RULE_06
          if (end_pos == SLOT_NONE) begin
            state_d = ST_FETCH; // RULE_08
          end
        end else begin
          // chain runs off the end: keep it for the next packet
          carry_v_d = pk_v; // RULE_05
          carry_i_d = pk_i;
          carry_n_d = cnt;
          state_d = ST_FETCH; // RULE_08
        end
      end
      default: begin
        // a broken one-hot code falls back to a fresh fetch
        state_d = ST_FETCH;
      end
    endcase
  end

  // sequencer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= ST_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // next slot to scan in the buffered fetch packet
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_d;
    end
  end

  // program counter, one fetch packet per step
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pc_q <= RESET_PC;
    end else begin
      pc_q <= pc_d;
    end
  end

  // carried chain: lanes, words and count load together; a closed packet clears lanes and count only
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      carry_v_q <= '0;
      carry_i_q <= '0;
      carry_n_q <= '0;
    end else begin
      carry_v_q <= carry_v_d;
      carry_i_q <= carry_i_d;
      carry_n_q <= carry_n_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // request pulse; the self-clear keeps it to one cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      FETCH_REQ <= 1'b0;
    end else begin
      FETCH_REQ <= in_fetch && !FETCH_REQ; // RULE_08
    end
  end

  // address tracks the counter, so it moves once the data has been taken
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      FETCH_ADDR <= RESET_PC;
    end else begin
      FETCH_ADDR <= pc_q; // RULE_01
    end
  end

  // issue strobe, one execute packet per clock
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ISSUE_VALID <= 1'b0;
    end else begin
      ISSUE_VALID <= fire; // RULE_07
    end
  end

  // lane valids only ride with the issue strobe
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      UNIT_VALID <= '0;
    end else begin
      UNIT_VALID <= fire ? pk_v : '0; // RULE_09
    end
  end

  // idle lanes reload every clock with whatever pk_i holds, stale carried words included, which saves a clear mux per lane
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      UNIT_INS <= '0;
    end else begin
      UNIT_INS <= pk_i;
    end
  end
endmodule
`default_nettype wire

/* vxd_dispatch_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ***
// port checks
// ***
module vxd_dispatch_monitor
  import vxd_pkg::*;
(
  // clock, reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // watched ports
  input wire logic FETCH_REQ,
  input wire logic [ADDR_W-1:0] FETCH_ADDR,
  input wire logic FETCH_VALID,
  input wire logic ISSUE_VALID,
  input wire logic [UNITS-1:0] UNIT_VALID,
  input wire logic [UNITS-1:0][INS_W-1:0] UNIT_INS
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // last issue, then one idle cycle
  sequence s_drain; ISSUE_VALID ##1 !ISSUE_VALID; endsequence
  a_req_pulse: assert property (FETCH_REQ |=> !FETCH_REQ) else $error("req");
  // no issue in the request cycle or the two cycles after it
  sequence s_quiet; !ISSUE_VALID [*3]; endsequence
  // address steps only two edges after a packet was taken
  a_addr_hold: assert property ($changed(FETCH_ADDR) |->
    $past(FETCH_VALID, 2)) else $error("adr");
  a_req_drained: assert property (FETCH_REQ |-> s_quiet) else $error("early");
  a_refetch_gap: assert property (s_drain |-> ##[0:1] FETCH_REQ) else $error("late");
  a_first_issue: assert property (FETCH_VALID |-> ##2 ISSUE_VALID) else $error("iss");
  a_lanes_idle: assert property (!ISSUE_VALID |-> !(|UNIT_VALID)) else $error("idle");
  a_lanes_busy: assert property (ISSUE_VALID |-> |UNIT_VALID) else $error("busy");
  // lanes are indexed by unit, so the select field must match the lane
  for (genvar k = 0; k < UNITS; k++) begin : g_lane
    a_lane_unit: assert property (UNIT_VALID[k] |->
      UNIT_INS[k][USEL_LO +: USEL_W] == USEL_W'(k)) else $error("unit");
  end
endmodule
bind vxd_dispatch vxd_dispatch_monitor u_mon (.CLK_SYS, .RST, .FETCH_REQ, .FETCH_ADDR,
  .FETCH_VALID, .ISSUE_VALID, .UNIT_VALID, .UNIT_INS);
`default_nettype wire

/* vxd_pmem.sv */
`timescale 1ns/1ps
`default_nettype none
// ***
// program memory model
// ***
module vxd_pmem
  import vxd_pkg::*;
(
  // clock
  input wire logic CLK_SYS,
  // fetch path
  input wire logic FETCH_REQ,
  input wire logic [ADDR_W-1:0] FETCH_ADDR,
  output logic FETCH_VALID,
  output logic [FP_W-1:0] FETCH_DATA
);
  logic [FP_W-1:0] mem [32];
  // random latency; data scrambled once released so stale values never match
  initial begin
    FETCH_VALID = 1'b0;
    FETCH_DATA = '1;
    forever begin
      @(posedge CLK_SYS);
      if (FETCH_REQ === 1'b1) begin
        repeat ($urandom_range(2)) @(posedge CLK_SYS);
        #1 FETCH_VALID = 1'b1;
        FETCH_DATA = mem[FETCH_ADDR[9:5]];
        @(posedge CLK_SYS);
        #1 FETCH_VALID = 1'b0;
        FETCH_DATA = ~FETCH_DATA;
      end
    end
  end
endmodule
`default_nettype wire

/* tb_vliw_execute_packet_dispatch.sv */
`timescale 1ns/1ps
`default_nettype none
// ***
// bench
// ***
module tb_vliw_execute_packet_dispatch import vxd_pkg::*; ();
  logic clk_sys = 1'b0, rst = 1'b1, req, ivld, fvld;
  logic [ADDR_W-1:0] addr;
  logic [FP_W-1:0] fdat;
  logic [UNITS-1:0] uv, e_uv = '0;
  logic [UNITS-1:0][INS_W-1:0] ui, e_ui = '0;
  logic [INS_W-1:0] w;
  logic [UNITS-1:0] ev_q [$];
  logic [UNITS-1:0][INS_W-1:0] ei_q [$];
  int err_total = 0, samples_checked = 0, n = 0, nreq = 0;
  initial forever #5 clk_sys = ~clk_sys;
  vxd_dispatch u_dut (.CLK_SYS(clk_sys), .RST(rst), .FETCH_REQ(req), .FETCH_ADDR(addr),
    .FETCH_VALID(fvld), .FETCH_DATA(fdat), .ISSUE_VALID(ivld), .UNIT_VALID(uv), .UNIT_INS(ui));
  vxd_pmem u_mem (.CLK_SYS(clk_sys), .FETCH_REQ(req), .FETCH_ADDR(addr), .FETCH_VALID(fvld),
    .FETCH_DATA(fdat));
  task automatic chk(input logic [FP_W-1:0] g, input logic [FP_W-1:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // outputs settled at the falling edge
  always @(negedge clk_sys) begin
    if (!rst && req === 1'b1) begin
      chk(addr, nreq * FP_BYTES);
      nreq++;
    end
    if (!rst && ivld === 1'b1 && ev_q.size() > 0) begin
      chk(uv, ev_q[0]);
      for (int k = 0; k < UNITS; k++) begin
        if (uv[k] === 1'b1) chk(ui[k], ei_q[0][k]);
      end
      void'(ev_q.pop_front());
      void'(ei_q.pop_front());
    end
  end
  // packet 0 all singles, packet 1 one full chain, rest random chains
  initial begin
    void'($urandom(32'h66cb));
    for (int p = 0; p < 32; p++) begin
      for (int s = 0; s < SLOTS; s++) begin
        w = $urandom;
        w[0] = (p == 1) || (p > 1 && $urandom_range(3) != 0);
        u_mem.mem[p][s*INS_W +: INS_W] = w;
        e_uv[w[USEL_LO +: USEL_W]] = 1'b1;
        e_ui[w[USEL_LO +: USEL_W]] = w;
        n++;
        if (!w[0] || n == SLOTS) begin
          ev_q.push_back(e_uv);
          ei_q.push_back(e_ui);
          e_uv = '0;
          e_ui = '0;
          n = 0;
        end
      end
    end
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int i = 0; i < 3000 && ev_q.size() > 0; i++) @(posedge clk_sys);
    if (ev_q.size() > 0) err_total++;
    summarize();
  end
endmodule
`default_nettype wire
